// ==== rtl/ssc_regs.vh ====
// Register map, field positions and reset values for the serial controller
// Operation
// - Slave role: select is input; low activates, MISO driven only if enabled by software. Code drives select in slave role too when SSC_PIN_SEL_OE is set.
// - Slave role: select high immediately resets bit counter and drops partial byte.
// - Master role with select as output: plain output, no effect on logic.
// - Master with select input driven low: clear master bit, become slave, release MOSI/SCK.
// - That demotion also sets the transfer-done flag.
// - Interrupt request needs done flag, control bit 7 and global enable.
// - Control bit 6 enables the interface; no transfer without it.
// - Control bit 5 one shifts LSB first, zero MSB first.
// - Control bit 4 one selects master role, zero slave role.
// - Control bit 3 sets SCK idle level and leading edge direction.
// - Control bit 2 zero samples on leading edge, one on trailing edge.
// - Master SCK divider from double-rate and rate bits: 4,16,64,128 / 2,8,32,64.
// - Status bit 7 set at transfer end; cleared by vector or status read then data access.
// - Status bit 6 set on data write during transfer; cleared by same sequence.
// - Status bits 5..1 read as zero.
// - Status bit 0 doubles master SCK rate, minimum period two clocks.
// - Data write starts transmission; data read returns receive buffer.
// - Shift and capture on opposite SCK edges; modes 0..3 from polarity/phase.
// - Master data write runs clock for eight bits, stops, sets done flag.
// - Transmit single buffered; receive double buffered, unread byte overwritten.
// - Slave with select high: MISO released, no shifting, data may be preloaded.
`ifndef SSC_REGS_VH
`define SSC_REGS_VH

`define SSC_ADDR_CONTROL     8'h00
`define SSC_ADDR_STATUS      8'h04
`define SSC_ADDR_DATA        8'h08
`define SSC_ADDR_PINCFG      8'h0C

`define SSC_CTL_IRQ_EN       7
`define SSC_CTL_ENABLE       6
`define SSC_CTL_LSB_FIRST    5
`define SSC_CTL_MASTER       4
`define SSC_CTL_IDLE_LEVEL   3
`define SSC_CTL_PHASE        2
`define SSC_CTL_RATE_HI      1
`define SSC_CTL_RATE_LO      0

`define SSC_STS_DONE         7
`define SSC_STS_WRITE_COLLISION_FLAG         6
`define SSC_STS_DOUBLE       0

`define SSC_PIN_MISO_OE      0
`define SSC_PIN_SEL_OE       1
`define SSC_PIN_SEL_LEVEL    2

`define SSC_CONTROL_RESET    8'h00
`define SSC_STATUS_RESET     8'h00
`define SSC_BITS_PER_BYTE    4'h8

`endif

// ==== rtl/ssc_controller.v ====
// Byte serial peripheral interface controller, master or slave, AHB-Lite registers
`timescale 1ns/1ps
`include "ssc_regs.vh"

module ssc_controller (
    // Clock and reset
    input  wire        ref_clk_in,
    input  wire        rst_in,
    // AHB-Lite slave
    input  wire        hsel_in,
    input  wire [31:0] haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire [2:0]  hsize_in,
    input  wire [31:0] hwdata_in,
    input  wire        hready_in,
    output reg  [31:0] hrdata_out,
    output wire        hreadyout_out,
    output wire        hresp_out,
    // Interrupt
    input  wire        global_irq_en_in,
    input  wire        irq_vector_ack_in,
    output wire        irq_out,
    // Serial clock pin
    input  wire        sck_in,
    output reg         sck_out,
    output wire        sck_oe_out,
    // Master out, slave in
    input  wire        mosi_in,
    output reg         mosi_out,
    output wire        mosi_oe_out,
    // Master in, slave out
    input  wire        miso_in,
    output reg         miso_out,
    output wire        miso_oe_out,
    // Slave select, active low
    input  wire        sel_n_in,
    output wire        sel_n_out,
    output wire        sel_n_oe_out
);

    localparam ST_IDLE  = 2'h0;
    localparam ST_SHIFT = 2'h1;

    reg  [7:0]  control_reg;
    reg         done_reg;
    reg         write_collision_flag_reg;
    reg         double_reg;
    reg  [2:0]  pincfg_reg;
    reg  [7:0]  shift_reg;
    reg  [7:0]  rx_buf_reg;
    reg  [3:0]  bit_cnt_reg;
    reg  [1:0]  state_reg;
    reg  [6:0]  div_cnt_reg;
    reg         sample_bit_reg;
    reg         sck_prev_reg;
    reg         clr_armed_reg;
    reg         dph_valid_reg;
    reg         dph_write_reg;
    reg  [7:0]  dph_addr_reg;

    wire enable     = control_reg[`SSC_CTL_ENABLE];
    wire lsb_first  = control_reg[`SSC_CTL_LSB_FIRST];
    wire master     = control_reg[`SSC_CTL_MASTER];
    wire idle_level = control_reg[`SSC_CTL_IDLE_LEVEL];
    wire phase      = control_reg[`SSC_CTL_PHASE];
    wire sel_is_out = pincfg_reg[`SSC_PIN_SEL_OE];
    wire busy       = (state_reg == ST_SHIFT);

    // Register bus: zero-wait, always OKAY
    wire addr_phase = hsel_in && hready_in && htrans_in[1];
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    wire wr_ctl  = dph_valid_reg && dph_write_reg && dph_addr_reg == `SSC_ADDR_CONTROL;
    wire wr_sts  = dph_valid_reg && dph_write_reg && dph_addr_reg == `SSC_ADDR_STATUS;
    wire wr_dat  = dph_valid_reg && dph_write_reg && dph_addr_reg == `SSC_ADDR_DATA;
    wire wr_pin  = dph_valid_reg && dph_write_reg && dph_addr_reg == `SSC_ADDR_PINCFG;
    wire rd_sts  = dph_valid_reg && !dph_write_reg && dph_addr_reg == `SSC_ADDR_STATUS;
    wire acc_dat = dph_valid_reg && dph_addr_reg == `SSC_ADDR_DATA;

    wire [7:0] status_word = {done_reg, write_collision_flag_reg, 5'h00, double_reg};

    always @* begin
        hrdata_out = 32'h0000_0000;
        if (dph_valid_reg && !dph_write_reg) begin
            case (dph_addr_reg)
                `SSC_ADDR_CONTROL: hrdata_out = {24'h000000, control_reg};
                `SSC_ADDR_STATUS:  hrdata_out = {24'h000000, status_word};
                `SSC_ADDR_DATA:    hrdata_out = {24'h000000, rx_buf_reg};
                `SSC_ADDR_PINCFG:  hrdata_out = {29'h00000000, pincfg_reg};
                default:           hrdata_out = 32'h0000_0000;
            endcase
        end
    end

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            dph_valid_reg <= 1'b0;
            dph_write_reg <= 1'b0;
            dph_addr_reg  <= 8'h00;
        end else begin
            dph_valid_reg <= addr_phase;
            if (addr_phase) begin
                dph_write_reg <= hwrite_in;
                dph_addr_reg  <= {haddr_in[7:2], 2'b00};
            end
        end
    end

    // Role and pin directions
    wire slave_active = enable && !master && !sel_n_in;
    wire demote       = enable && master && !sel_is_out && !sel_n_in;
    assign sck_oe_out   = enable && master;
    assign mosi_oe_out  = enable && master;
    assign miso_oe_out  = slave_active && pincfg_reg[`SSC_PIN_MISO_OE];
    assign sel_n_oe_out = sel_is_out;
    assign sel_n_out    = pincfg_reg[`SSC_PIN_SEL_LEVEL];
    assign irq_out = done_reg && control_reg[`SSC_CTL_IRQ_EN] && global_irq_en_in;

    // Master divider: half period in system clocks
    reg [6:0] half_period;
    always @* begin
        case ({double_reg, control_reg[`SSC_CTL_RATE_HI], control_reg[`SSC_CTL_RATE_LO]})
            3'h0:    half_period = 7'h02;  // /4
            3'h1:    half_period = 7'h08;  // /16
            3'h2:    half_period = 7'h20;  // /64
            3'h3:    half_period = 7'h40;  // /128
            3'h4:    half_period = 7'h01;  // /2
            3'h5:    half_period = 7'h04;  // /8
            3'h6:    half_period = 7'h10;  // /32
            3'h7:    half_period = 7'h20;  // /64
            default: half_period = 7'h02;
        endcase
    end

    // Slave edge detection on SCK, inputs already synchronous
    wire sck_rise  = sck_in && !sck_prev_reg;
    wire sck_fall  = !sck_in && sck_prev_reg;
    wire lead_edge = idle_level ? sck_fall : sck_rise;
    wire trail_edge = idle_level ? sck_rise : sck_fall;
    wire s_sample  = phase ? trail_edge : lead_edge;
    wire s_setup   = phase ? lead_edge : trail_edge;

    wire out_bit   = lsb_first ? shift_reg[0] : shift_reg[7];
    wire in_bit    = master ? miso_in : mosi_in;
    wire [7:0] shifted = lsb_first ? {in_bit, shift_reg[7:1]} : {shift_reg[6:0], in_bit};

    wire load_ok    = wr_dat && !busy;
    wire clear_seq  = clr_armed_reg && acc_dat;
    reg  byte_done;

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            control_reg    <= `SSC_CONTROL_RESET;
            done_reg       <= 1'b0;
            write_collision_flag_reg       <= 1'b0;
            double_reg     <= 1'b0;
            pincfg_reg     <= 3'h4;
            shift_reg      <= 8'h00;
            rx_buf_reg     <= 8'h00;
            bit_cnt_reg    <= 4'h0;
            state_reg      <= ST_IDLE;
            div_cnt_reg    <= 7'h00;
            sample_bit_reg <= 1'b0;
            sck_prev_reg   <= 1'b0;
            sck_out        <= 1'b0;
            mosi_out       <= 1'b0;
            miso_out       <= 1'b0;
            clr_armed_reg  <= 1'b0;
            byte_done      <= 1'b0;
        end else begin
            sck_prev_reg <= sck_in;
            byte_done    <= 1'b0;
            if (wr_ctl)
                control_reg <= hwdata_in[7:0];
            if (wr_sts)
                double_reg <= hwdata_in[`SSC_STS_DOUBLE];
            if (wr_pin)
                pincfg_reg <= hwdata_in[2:0];
            if (demote)
                control_reg[`SSC_CTL_MASTER] <= 1'b0;
            if (rd_sts)
                clr_armed_reg <= done_reg || write_collision_flag_reg;
            else if (acc_dat)
                clr_armed_reg <= 1'b0;

            // Shift engine
            if (!enable || (!master && sel_n_in) || demote) begin
                state_reg   <= ST_IDLE;
                bit_cnt_reg <= 4'h0;
                div_cnt_reg <= 7'h00;
                sck_out     <= idle_level;
                if (load_ok)
                    shift_reg <= hwdata_in[7:0];
            end else if (master) begin
                case (state_reg)
                    ST_IDLE: begin
                        sck_out <= idle_level;
                        if (load_ok) begin
                            shift_reg   <= hwdata_in[7:0];
                            state_reg   <= ST_SHIFT;
                            bit_cnt_reg <= 4'h0;
                            div_cnt_reg <= 7'h00;
                            mosi_out    <= lsb_first ? hwdata_in[0] : hwdata_in[7];
                        end
                    end
                    ST_SHIFT: begin
                        if (div_cnt_reg == half_period - 7'h01) begin
                            div_cnt_reg <= 7'h00;
                            sck_out     <= !sck_out;
                            if (sck_out == idle_level) begin
                                // Leading edge
                                if (!phase)
                                    sample_bit_reg <= miso_in;
                                else if (bit_cnt_reg != 4'h0)
                                    mosi_out <= out_bit;
                            end else begin
                                // Trailing edge ends one bit
                                shift_reg <= lsb_first
                                    ? {(phase ? miso_in : sample_bit_reg), shift_reg[7:1]}
                                    : {shift_reg[6:0], (phase ? miso_in : sample_bit_reg)};
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                                if (!phase)
                                    mosi_out <= lsb_first ? shift_reg[1] : shift_reg[6];
                                if (bit_cnt_reg == `SSC_BITS_PER_BYTE - 4'h1) begin
                                    state_reg <= ST_IDLE;
                                    byte_done <= 1'b1;
                                end
                            end
                        end else begin
                            div_cnt_reg <= div_cnt_reg + 7'h01;
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end else begin
                // Slave, select low
                if (load_ok)
                    shift_reg <= hwdata_in[7:0];
                if (state_reg == ST_IDLE && !phase)
                    miso_out <= lsb_first ? shift_reg[0] : shift_reg[7];
                if (s_sample) begin
                    state_reg      <= ST_SHIFT;
                    sample_bit_reg <= mosi_in;
                end
                if (s_setup && state_reg == ST_SHIFT) begin
                    shift_reg   <= lsb_first ? {sample_bit_reg, shift_reg[7:1]}
                                             : {shift_reg[6:0], sample_bit_reg};
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    miso_out    <= lsb_first ? shift_reg[1] : shift_reg[6];
                    if (bit_cnt_reg == `SSC_BITS_PER_BYTE - 4'h1) begin
                        state_reg   <= ST_IDLE;
                        bit_cnt_reg <= 4'h0;
                        byte_done   <= 1'b1;
                    end
                end else if (s_setup && phase)
                    miso_out <= out_bit;
                if (phase && s_sample && bit_cnt_reg == `SSC_BITS_PER_BYTE - 4'h1) begin
                    shift_reg   <= shifted;
                    state_reg   <= ST_IDLE;
                    bit_cnt_reg <= 4'h0;
                    byte_done   <= 1'b1;
                end
            end

            if (byte_done)
                rx_buf_reg <= shift_reg;

            // Flags: set wins over clear
            if (byte_done || demote)
                done_reg <= 1'b1;
            else if (irq_vector_ack_in || clear_seq)
                done_reg <= 1'b0;
            if (wr_dat && busy)
                write_collision_flag_reg <= 1'b1;
            else if (clear_seq)
                write_collision_flag_reg <= 1'b0;
        end
    end

endmodule // ssc_controller

// ==== verification/ssc_controller_props.sv ====
// Port-level assertions for the serial controller
`timescale 1ns/1ps
`include "ssc_regs.vh"
module ssc_controller_props (
    // Clock, reset and bus
    input wire        ref_clk_in,
    input wire        rst_in,
    input wire        hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0]  htrans_in,
    input wire        hwrite_in,
    input wire        hready_in,
    input wire [31:0] hrdata_out,
    input wire        hreadyout_out,
    input wire        hresp_out,
    // Interrupt and pins
    input wire        global_irq_en_in,
    input wire        irq_vector_ack_in,
    input wire        irq_out,
    input wire        sck_oe_out,
    input wire        mosi_oe_out,
    input wire        miso_oe_out,
    input wire        sel_n_in,
    input wire        sel_n_oe_out
);
    reg  rd_reg;
    reg  rd_sts_reg;
    reg  wr_reg;
    wire take = hsel_in && hready_in && htrans_in[1] && !rst_in;
    wire lost = !sel_n_in && !sel_n_oe_out;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    always @(posedge ref_clk_in) begin
        rd_reg     <= take && !hwrite_in;
        rd_sts_reg <= take && !hwrite_in && haddr_in[7:0] == `SSC_ADDR_STATUS;
        wr_reg     <= take && hwrite_in;
    end
    a_bus_okay: assert property (hreadyout_out && !hresp_out)
        else $error("bus answer not ready or not okay");
    a_upper_zero: assert property (rd_reg |-> hrdata_out[31:8] == 24'h000000)
        else $error("read data above the byte not zero");
    a_reserved_zero: assert property (rd_sts_reg |-> hrdata_out[5:1] == 5'h00)
        else $error("reserved status bits not zero");
    a_irq_gated: assert property (irq_out |-> global_irq_en_in)
        else $error("interrupt without global enable");
    a_vector_clear: assert property (irq_vector_ack_in && !sck_oe_out |=> !irq_out)
        else $error("interrupt stays after vector acknowledge");
    a_roles_apart: assert property (!(miso_oe_out && mosi_oe_out))
        else $error("miso and mosi driven together");
    a_sck_with_mosi: assert property (sck_oe_out == mosi_oe_out)
        else $error("sck and mosi drive differ");
    a_demote_bound: assert property (mosi_oe_out && lost |-> ##[1:3] !mosi_oe_out)
        else $error("master not released after select low");
    a_master_holds: assert property ($fell(mosi_oe_out) |-> $past(wr_reg) ||
        $past(lost) || $past(lost, 2) || $past(lost, 3))
        else $error("master role dropped without cause");
    a_miso_released: assert property ($rose(sel_n_in) ##1 sel_n_in |-> !miso_oe_out)
        else $error("miso driven while deselected");
endmodule // ssc_controller_props

bind ssc_controller ssc_controller_props u_props (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
    .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .global_irq_en_in(global_irq_en_in), .irq_vector_ack_in(irq_vector_ack_in),
    .irq_out(irq_out), .sck_oe_out(sck_oe_out), .mosi_oe_out(mosi_oe_out),
    .miso_oe_out(miso_oe_out), .sel_n_in(sel_n_in), .sel_n_oe_out(sel_n_oe_out));

// ==== verification/ssc_slave_model.sv ====
// Behavioural external slave on the far side of the master link
`timescale 1ns/1ps
module ssc_slave_model (
    // Link pins
    input  wire       sck_in,
    input  wire       mosi_in,
    input  wire       sel_n_in,
    output reg        miso_out,
    // Mode and data
    input  wire       clock_idle_level_in,
    input  wire       clock_sample_phase_in,
    input  wire       lsb_in,
    input  wire [7:0] tx_byte_in,
    output reg  [7:0] rx_byte_out
);
    integer idx;
    wire    lead = sck_in ^ clock_idle_level_in;
    function integer pos(input integer n);
        pos = lsb_in ? n : 7 - n;
    endfunction
    initial begin
        idx = 0;
        miso_out = 1'b0;
        rx_byte_out = 8'h00;
    end
    always @(negedge sel_n_in) begin
        idx = 0;
        if (!clock_sample_phase_in) miso_out = tx_byte_in[pos(0)];
    end
    // Released line shows the inverse of its last level
    always @(posedge sel_n_in) miso_out = ~miso_out;
    always @(posedge lead) if (!sel_n_in && idx < 8) begin
        if (clock_sample_phase_in) miso_out = tx_byte_in[pos(idx)];
        else rx_byte_out[pos(idx)] = mosi_in;
    end
    always @(negedge lead) if (!sel_n_in && idx < 8) begin
        if (clock_sample_phase_in) rx_byte_out[pos(idx)] = mosi_in;
        idx = idx + 1;
        if (!clock_sample_phase_in && idx < 8) miso_out = tx_byte_in[pos(idx)];
    end
endmodule // ssc_slave_model

// ==== verification/tb.sv ====
// Self-checking bench for the serial controller
`timescale 1ns/1ps
`include "ssc_regs.vh"
module tb;
    reg         clk, rst, hwrite, gie, ack, b_sck, b_mosi, b_sel_n, clock_idle_level, clock_sample_phase, lsb, sck_d;
    reg  [1:0]  htrans;
    reg  [31:0] haddr, hwdata, rd_q, rd;
    reg  [7:0]  ptx, sb;
    wire [31:0] hrdata;
    wire        hready, hresp, irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    wire        sel_o, sel_oe, p_miso;
    wire [7:0]  prx;
    wire        sck_pin  = sck_oe ? sck_o : b_sck;
    wire        mosi_pin = mosi_oe ? mosi_o : b_mosi;
    wire        miso_pin = miso_oe ? miso_o : p_miso;
    wire        sel_pin  = sel_oe ? sel_o : b_sel_n;
    integer     bad_count, checks_done, cycles, hp, hp_cnt, i, k;
    ssc_controller DUT (
        .ref_clk_in(clk), .rst_in(rst), .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .global_irq_en_in(gie), .irq_vector_ack_in(ack), .irq_out(irq),
        .sck_in(sck_pin), .sck_out(sck_o), .sck_oe_out(sck_oe),
        .mosi_in(mosi_pin), .mosi_out(mosi_o), .mosi_oe_out(mosi_oe),
        .miso_in(miso_pin), .miso_out(miso_o), .miso_oe_out(miso_oe),
        .sel_n_in(sel_pin), .sel_n_out(sel_o), .sel_n_oe_out(sel_oe));
    ssc_slave_model u_slave (
        .sck_in(sck_pin), .mosi_in(mosi_pin), .sel_n_in(sel_oe ? sel_o : 1'b1),
        .miso_out(p_miso), .clock_idle_level_in(clock_idle_level), .clock_sample_phase_in(clock_sample_phase), .lsb_in(lsb),
        .tx_byte_in(ptx), .rx_byte_out(prx));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Read data capture and sck half period measure
    always @(posedge clk) begin
        rd_q <= hrdata;
        sck_d <= sck_o;
        hp_cnt <= (sck_d != sck_o) ? 1 : hp_cnt + 1;
        if (sck_d != sck_o) hp <= hp_cnt;
        cycles = cycles + 1;
        if (cycles == 60000) begin
            bad_count = bad_count + 1;
            results;
        end
    end
    function integer divof(input [2:0] c);
        case (c)
            3'd0: divof = 4;
            3'd1: divof = 16;
            3'd2: divof = 64;
            3'd3: divof = 128;
            3'd4: divof = 2;
            3'd5: divof = 8;
            3'd6: divof = 32;
            default: divof = 64;
        endcase
    endfunction
    task results;
        begin
            if (bad_count == 0 && checks_done > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    task chk(input [8*10-1:0] name, input [31:0] exp, input [31:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("ERROR %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task bus(input [7:0] a, input w, input [31:0] wd);
        begin
            haddr <= {24'h000000, a};
            hwrite <= w;
            htrans <= 2'b10;
            @(posedge clk);
            while (hready !== 1'b1) @(posedge clk);
            htrans <= 2'b00;
            hwdata <= wd;
            @(posedge clk);
            while (hready !== 1'b1) @(posedge clk);
            #1 rd = rd_q;
        end
    endtask
    task rdchk(input [7:0] a, input [31:0] e);
        begin
            bus(a, 1'b0, 32'h0);
            chk("register", e, rd);
        end
    endtask
    task wait_done;
        begin
            k = 0;
            rd = 32'h0;
            while (rd[7] !== 1'b1 && k < 2000) begin
                bus(`SSC_ADDR_STATUS, 1'b0, 32'h0);
                k = k + 1;
            end
            if (rd[7] !== 1'b1) bad_count = bad_count + 1;
        end
    endtask
    task sbit(input b);
        begin
            b_mosi <= b;
            repeat (4) @(posedge clk);
            b_sck <= 1'b1;
            repeat (4) @(posedge clk);
            b_sck <= 1'b0;
        end
    endtask
    initial begin
        {rst, hwrite, gie, ack, b_sck, b_mosi, b_sel_n} = 7'b1000001;
        {htrans, haddr, hwdata, clock_idle_level, clock_sample_phase, lsb, ptx} = 0;
        {bad_count, checks_done, cycles, hp_cnt, hp} = 0;
        sb = 8'h3C;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdchk(`SSC_ADDR_CONTROL, 32'h00);
        rdchk(`SSC_ADDR_PINCFG, 32'h04);
        bus(`SSC_ADDR_STATUS, 1'b1, 32'hFF);
        rdchk(`SSC_ADDR_STATUS, 32'h01);
        bus(8'h10, 1'b1, 32'hFF);
        rdchk(8'h10, 32'h00);
        bus(`SSC_ADDR_CONTROL, 1'b1, 32'h10);
        bus(`SSC_ADDR_DATA, 1'b1, 32'h55);
        repeat (40) @(posedge clk);
        chk("sck oe", 32'h0, {31'h0, sck_oe});
        rdchk(`SSC_ADDR_STATUS, 32'h01);
        for (i = 0; i < 8; i = i + 1) begin
            clock_idle_level = i[1];
            clock_sample_phase = i[0];
            lsb = i[2] ^ i[0];
            ptx = 8'h5A ^ (8'h13 * i[7:0]);
            bus(`SSC_ADDR_STATUS, 1'b1, {31'h0, i[2]});
            bus(`SSC_ADDR_CONTROL, 1'b1, {24'h0, 2'b01, lsb, 1'b1, clock_idle_level, clock_sample_phase, i[1:0]});
            bus(`SSC_ADDR_PINCFG, 1'b1, 32'h02);
            chk("sck idle", {31'h0, clock_idle_level}, {31'h0, sck_pin});
            chk("sel out", 32'h0, {31'h0, sel_pin});
            chk("mosi oe", 32'h1, {31'h0, mosi_oe});
            bus(`SSC_ADDR_DATA, 1'b1, 32'hC3 ^ i);
            wait_done;
            chk("sck half", divof(i[2:0]) / 2, hp);
            chk("sck rest", {31'h0, clock_idle_level}, {31'h0, sck_pin});
            chk("slave got", 32'hC3 ^ i, {24'h0, prx});
            rdchk(`SSC_ADDR_STATUS, {24'h0, 1'b1, 6'h00, i[2]});
            rdchk(`SSC_ADDR_DATA, {24'h0, ptx});
            rdchk(`SSC_ADDR_STATUS, {31'h0, i[2]});
            bus(`SSC_ADDR_PINCFG, 1'b1, 32'h04);
        end
        {clock_idle_level, clock_sample_phase, lsb, ptx} = {3'b000, 8'h96};
        bus(`SSC_ADDR_STATUS, 1'b1, 32'h00);
        bus(`SSC_ADDR_CONTROL, 1'b1, 32'h50);
        bus(`SSC_ADDR_PINCFG, 1'b1, 32'h02);
        bus(`SSC_ADDR_DATA, 1'b1, 32'h11);
        bus(`SSC_ADDR_DATA, 1'b1, 32'h22);
        wait_done;
        rdchk(`SSC_ADDR_STATUS, 32'hC0);
        chk("slave got", 32'h11, {24'h0, prx});
        rdchk(`SSC_ADDR_DATA, 32'h96);
        rdchk(`SSC_ADDR_STATUS, 32'h00);
        bus(`SSC_ADDR_PINCFG, 1'b1, 32'h04);
        bus(`SSC_ADDR_CONTROL, 1'b1, 32'hD0);
        b_sel_n <= 1'b0;
        repeat (4) @(posedge clk);
        chk("irq off", 32'h0, {31'h0, irq});
        chk("mosi oe", 32'h0, {31'h0, mosi_oe});
        gie <= 1'b1;
        repeat (2) @(posedge clk);
        chk("irq on", 32'h1, {31'h0, irq});
        rdchk(`SSC_ADDR_CONTROL, 32'hC0);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        repeat (2) @(posedge clk);
        chk("irq ack", 32'h0, {31'h0, irq});
        b_sel_n <= 1'b1;
        bus(`SSC_ADDR_CONTROL, 1'b1, 32'h40);
        bus(`SSC_ADDR_PINCFG, 1'b1, 32'h05);
        bus(`SSC_ADDR_DATA, 1'b1, 32'hA5);
        b_sel_n <= 1'b0;
        for (k = 0; k < 3; k = k + 1) sbit(1'b1);
        chk("miso oe", 32'h1, {31'h0, miso_oe});
        b_sel_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("miso oe", 32'h0, {31'h0, miso_oe});
        b_sel_n <= 1'b0;
        for (k = 0; k < 8; k = k + 1) sbit(sb[7 - k]);
        repeat (4) @(posedge clk);
        b_sel_n <= 1'b1;
        rdchk(`SSC_ADDR_STATUS, 32'h80);
        rdchk(`SSC_ADDR_DATA, 32'h3C);
        results;
    end
endmodule // tb
